// [core/aps_diag_time.sv]
// Purpose: per-phase duration of one diagnostic slot
// Assumes: select zero means the slot is off
// Notes: each slot runs two equal phases
`timescale 1ns/10ps
module aps_diag_time
  import aps_pkg::*;
#(
  parameter int ALTREF_CYC = ALTREF_PHASE_CYC
) (
  // selection
  input wire logic [3:0] diagSelect,
  // duration of one phase in clocks
  output logic [TMR_W-1:0] phaseCycles
);
  always_comb begin
    unique case (diagSelect)
      DIAG_OFF: phaseCycles = '0;
      DIAG_DIE_TEMP: phaseCycles = TMR_W'(DIE_TEMP_PHASE_CYC);
      DIAG_SUPPLY: phaseCycles = TMR_W'(SUPPLY_PHASE_CYC);
      DIAG_COMP_PATH: phaseCycles = TMR_W'(COMP_PATH_PHASE_CYC);
      DIAG_CELL_GAIN: phaseCycles = TMR_W'(GAIN_PHASE_CYC);
      DIAG_ALTREF: phaseCycles = TMR_W'(ALTREF_CYC);
      DIAG_DAC: phaseCycles = TMR_W'(DAC_PHASE_CYC);
      default: phaseCycles = TMR_W'(OTHER_PHASE_CYC);
    endcase
  end
endmodule

// [core/aps_pkg.sv]
// Purpose: constants, step enum and helpers for the pyramid acquisition sequencer
// Assumes: 125 MHz internal oscillator clock, times held in ns
// Notes: cycle counts round up to whole clocks
//
// How it works
// - host acquire write starts configured acquisition
// - acquire strobe always reads back zero
// - start taken when command reaches this device
// - done flag set after whole acquisition
// - type field writes ignored while done set
// - order select zero selects pyramid order
// - pump off, block, cells up, down, block
// - first_diag_slot two phases, second_diag_slot two, aux
// - pump recovery unless no oversample or last
// - repeat cycle per oversample, then done
// - 15us init, 27.75us block measurement
// - 6.38us cell setup when any cell
// - 9us per enabled cell per cycle
// - 5.44us per enabled aux input
// - 57us recovery between oversample cycles
// - die 32.44, supply 23.81, path 8.44us
// - gain 24.28, altref 86.44, dac 19.5, others 5.44us
// - fixed rate auto bias settles 6*settle
// - free run settle subtracts other times
package aps_pkg;
  localparam int CLK_PERIOD_NS = 8;

  function automatic int cyc_ceil(input int ns);
    return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction

  localparam int NUM_CELLS = 14;
  localparam int NUM_AUX = 6;
  localparam int TMR_W = 20;

  localparam int INIT_NS = 15000;
  localparam int BLK_PHASE_NS = 13875;
  localparam int CELL_SETUP_NS = 6380;
  localparam int CELL_PHASE_NS = 4500;
  localparam int AUX_CH_NS = 5440;
  localparam int RECOVER_NS = 57000;
  localparam int ENDPOINT_NS = 11200;
  localparam int COMPARATOR_ACCURACY_CHECK_NS = 13500;
  localparam int SETTLE_UNIT_NS = 6000;
  localparam int DIE_TEMP_PHASE_NS = 16220;
  localparam int SUPPLY_PHASE_NS = 11905;
  localparam int COMP_PATH_PHASE_NS = 4220;
  localparam int GAIN_PHASE_NS = 12140;
  localparam int ALTREF_PHASE_NS = 43220;
  localparam int DAC_PHASE_NS = 9750;
  localparam int OTHER_PHASE_NS = 2720;

  localparam int INIT_CYC = cyc_ceil(INIT_NS);
  localparam int BLK_PHASE_CYC = cyc_ceil(BLK_PHASE_NS);
  localparam int CELL_SETUP_CYC = cyc_ceil(CELL_SETUP_NS);
  localparam int CELL_PHASE_CYC = cyc_ceil(CELL_PHASE_NS);
  localparam int AUX_CH_CYC = cyc_ceil(AUX_CH_NS);
  localparam int RECOVER_CYC = cyc_ceil(RECOVER_NS);
  localparam int ENDPOINT_CYC = cyc_ceil(ENDPOINT_NS);
  localparam int COMPARATOR_ACCURACY_CHECK_CYC = cyc_ceil(COMPARATOR_ACCURACY_CHECK_NS);
  localparam int SETTLE_UNIT_CYC = cyc_ceil(SETTLE_UNIT_NS);
  localparam int DIE_TEMP_PHASE_CYC = cyc_ceil(DIE_TEMP_PHASE_NS);
  localparam int SUPPLY_PHASE_CYC = cyc_ceil(SUPPLY_PHASE_NS);
  localparam int COMP_PATH_PHASE_CYC = cyc_ceil(COMP_PATH_PHASE_NS);
  localparam int GAIN_PHASE_CYC = cyc_ceil(GAIN_PHASE_NS);
  localparam int ALTREF_PHASE_CYC = cyc_ceil(ALTREF_PHASE_NS);
  localparam int DAC_PHASE_CYC = cyc_ceil(DAC_PHASE_NS);
  localparam int OTHER_PHASE_CYC = cyc_ceil(OTHER_PHASE_NS);

  localparam logic [3:0] DIAG_OFF = 4'h0;
  localparam logic [3:0] DIAG_DIE_TEMP = 4'h1;
  localparam logic [3:0] DIAG_SUPPLY = 4'h2;
  localparam logic [3:0] DIAG_COMP_PATH = 4'h3;
  localparam logic [3:0] DIAG_CELL_GAIN = 4'h4;
  localparam logic [3:0] DIAG_ALTREF = 4'h5;
  localparam logic [3:0] DIAG_DAC = 4'h6;

  localparam logic ORDER_PYRAMID = 1'h0;
  localparam logic [1:0] RATE_FREE_RUN = 2'h0;
  localparam logic [2:0] OVS_NONE = 3'h0;
  localparam logic [3:0] TYPE_RESET = 4'h0;
  localparam logic [4:0] CELL_NONE = 5'h1f;

  typedef enum logic [4:0] {
    ST_IDLE, ST_INIT, ST_SETTLE, ST_PUMP_OFF, ST_BLK1, ST_SETUP, ST_CELL_UP,
    ST_CELL_DN, ST_BLK2, ST_DIAG1A, ST_DIAG1B, ST_DIAG2A, ST_DIAG2B, ST_AUX,
    ST_RECOVER, ST_ENDPOINT, ST_COMPARATOR_ACCURACY_CHECK
  } aps_step_e;

  // number of measurement cycles; 0 means a single cycle
  function automatic logic [7:0] ovs_total(input logic [2:0] code);
    if (code == OVS_NONE) return 8'h01;
    if (code >= 3'h6) return 8'h80;
    return 8'(8'h01 << (code + 3'h1));
  endfunction
endpackage

// [core/aps_sequencer.sv]
// Purpose: pyramid-order acquisition sequencer with oversampling and pump control
// Assumes: host write pulses arrive synchronous to clk, one cycle each
// Notes: configuration is captured when an acquisition starts
`timescale 1ns/10ps
module aps_sequencer
  import aps_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYC,
  parameter int ALTREF_CYCLES = ALTREF_PHASE_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // acquisition control register writes
  input wire logic acquireWrite,
  input wire logic acquisitionTypeWrite,
  input wire logic [3:0] acquisitionTypeIn,
  input wire logic doneClearWrite,
  // configuration
  input wire logic conversionOrderSelect,
  input wire logic [2:0] oversampleCount,
  input wire logic blockMeasureEnable,
  input wire logic [NUM_CELLS-1:0] cellEnableMask,
  input wire logic [3:0] firstDiagSelect,
  input wire logic [3:0] secondDiagSelect,
  input wire logic [NUM_AUX-1:0] auxEnableMask,
  input wire logic [9:0] auxSettleTime,
  input wire logic thermistorBiasAuto,
  input wire logic [1:0] sampleRateSelect,
  input wire logic adcEndpointCheckEnable,
  input wire logic comparatorAccuracyCheckEnable,
  // status
  output logic acquireStrobeReadback,
  output logic acquisitionDoneFlag,
  output logic [3:0] acquisitionTypeField,
  output logic acquisitionBusy,
  output logic hvPumpEnable,
  output logic [4:0] activeStep,
  output logic [4:0] activeCell,
  output logic [7:0] oversampleIndex
);
  aps_step_e step_reg, step_next;
  logic [4:0] cell_reg, cell_next;
  logic [7:0] cyc_reg, cyc_next;
  logic done_reg, done_next;
  logic [3:0] type_reg, type_next;
  logic busy_reg, busy_next;
  logic pump_reg, pump_next;
  logic strobeRb_reg;
  logic blk_reg, endp_reg, comp_reg, auto_reg, freeRun_reg;
  logic [NUM_CELLS-1:0] cells_reg;
  logic [NUM_AUX-1:0] aux_reg;
  logic [3:0] d1_reg, d2_reg;
  logic [7:0] ovsTot_reg;
  logic [9:0] settleT_reg;
  logic latchCfg;
  logic loadTmr;
  logic tmrExpire;
  logic [TMR_W-1:0] loadCount;
  logic [TMR_W-1:0] d1Cyc, d2Cyc, settleCyc, fixedSettle, otherTime;
  logic lastCycle, start, anyCell, anyAux;

  function automatic logic [4:0] scan_cell(input logic [NUM_CELLS-1:0] mask,
                                           input logic [4:0] from, input logic up);
    logic [4:0] found;
    found = CELL_NONE;
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (up && mask[NUM_CELLS-1-i] && (5'(NUM_CELLS-1-i) >= from)) begin
        found = 5'(NUM_CELLS-1-i);
      end
      if (!up && mask[i] && (5'(i) <= from)) begin
        found = 5'(i);
      end
    end
    return found;
  endfunction

  function automatic int count_ones(input logic [NUM_CELLS-1:0] bits);
    int n;
    n = 0;
    for (int i = 0; i < NUM_CELLS; i++) begin
      n = n + int'(bits[i]);
    end
    return n;
  endfunction

  // fixed pyramid order of steps
  function automatic aps_step_e follow(input aps_step_e s, input logic last);
    unique case (s)
      ST_IDLE: return ST_INIT;
      ST_INIT: return ST_SETTLE;
      ST_SETTLE: return ST_PUMP_OFF;
      ST_PUMP_OFF: return ST_BLK1;
      ST_BLK1: return ST_SETUP;
      ST_SETUP: return ST_CELL_UP;
      ST_CELL_UP: return ST_CELL_DN;
      ST_CELL_DN: return ST_BLK2;
      ST_BLK2: return ST_DIAG1A;
      ST_DIAG1A: return ST_DIAG1B;
      ST_DIAG1B: return ST_DIAG2A;
      ST_DIAG2A: return ST_DIAG2B;
      ST_DIAG2B: return ST_AUX;
      ST_AUX: return last ? ST_ENDPOINT : ST_RECOVER;
      ST_RECOVER: return ST_PUMP_OFF;
      ST_ENDPOINT: return ST_COMPARATOR_ACCURACY_CHECK;
      ST_COMPARATOR_ACCURACY_CHECK: return ST_IDLE;
    endcase
  endfunction

  assign anyCell = |cells_reg;
  assign anyAux = |aux_reg;
  assign lastCycle = (cyc_reg + 8'h01) == ovsTot_reg;
  assign start = acquireWrite && (step_reg == ST_IDLE)
                 && (conversionOrderSelect == ORDER_PYRAMID);

  aps_diag_time #(.ALTREF_CYC(ALTREF_CYCLES)) u_first_diag_slot (
    .diagSelect(d1_reg),
    .phaseCycles(d1Cyc)
  );

  aps_diag_time #(.ALTREF_CYC(ALTREF_CYCLES)) u_second_diag_slot (
    .diagSelect(d2_reg),
    .phaseCycles(d2Cyc)
  );

  aps_step_timer #(.W(TMR_W)) u_timer (
    .clk(clk),
    .rst_b(rst_b),
    .load(loadTmr),
    .loadCount(loadCount),
    .expire(tmrExpire)
  );

  // aux settling, once per acquisition
  always_comb begin
    fixedSettle = TMR_W'(settleT_reg * SETTLE_UNIT_CYC);
    otherTime = TMR_W'(INIT_CYC) + (d1Cyc << 1) + (d2Cyc << 1);
    if (blk_reg) begin
      otherTime = otherTime + TMR_W'(2 * BLK_PHASE_CYC);
    end
    if (anyCell) begin
      otherTime = otherTime + TMR_W'(CELL_SETUP_CYC)
                  + TMR_W'(2 * CELL_PHASE_CYC * count_ones(cells_reg));
    end
    settleCyc = '0;
    if (auto_reg && anyAux) begin
      if (!freeRun_reg) begin
        settleCyc = fixedSettle;
      end else if (fixedSettle > otherTime) begin
        settleCyc = fixedSettle - otherTime;
      end
    end
  end

  // step sequencing
  always_comb begin
    aps_step_e s;
    logic skip;
    s = step_reg;
    skip = 1'b0;
    step_next = step_reg;
    cell_next = cell_reg;
    cyc_next = cyc_reg;
    loadTmr = 1'b0;
    latchCfg = 1'b0;
    done_next = done_reg;
    type_next = type_reg;
    if (start) begin
      latchCfg = 1'b1;
      cyc_next = 8'h00;
      step_next = ST_INIT;
      loadTmr = 1'b1;
    end else if (tmrExpire && step_reg != ST_IDLE) begin
      if (step_reg == ST_CELL_UP && cell_reg < 5'(NUM_CELLS - 1)
          && scan_cell(cells_reg, cell_reg + 5'h01, 1'b1) != CELL_NONE) begin
        cell_next = scan_cell(cells_reg, cell_reg + 5'h01, 1'b1);
        loadTmr = 1'b1;
      end else if (step_reg == ST_CELL_DN && cell_reg != 5'h00
                   && scan_cell(cells_reg, cell_reg - 5'h01, 1'b0) != CELL_NONE) begin
        cell_next = scan_cell(cells_reg, cell_reg - 5'h01, 1'b0);
        loadTmr = 1'b1;
      end else begin
        s = follow(step_reg, lastCycle);
        for (int i = 0; i < 16; i++) begin
          unique case (s)
            ST_SETTLE: skip = (settleCyc == '0);
            ST_BLK1, ST_BLK2: skip = !blk_reg;
            ST_SETUP, ST_CELL_UP, ST_CELL_DN: skip = !anyCell;
            ST_DIAG1A, ST_DIAG1B: skip = (d1_reg == DIAG_OFF);
            ST_DIAG2A, ST_DIAG2B: skip = (d2_reg == DIAG_OFF);
            ST_AUX: skip = !anyAux;
            ST_ENDPOINT: skip = !endp_reg;
            ST_COMPARATOR_ACCURACY_CHECK: skip = !comp_reg;
            default: skip = 1'b0;
          endcase
          if (skip) begin
            s = follow(s, lastCycle);
          end
        end
        if (s == ST_CELL_UP) begin
          cell_next = scan_cell(cells_reg, 5'h00, 1'b1);
        end
        if (s == ST_CELL_DN) begin
          cell_next = scan_cell(cells_reg, 5'(NUM_CELLS - 1), 1'b0);
        end
        if (s == ST_RECOVER) begin
          cyc_next = cyc_reg + 8'h01;
        end
        step_next = s;
        if (s == ST_IDLE) begin
          done_next = 1'b1;
        end else begin
          loadTmr = 1'b1;
        end
      end
    end
    if (doneClearWrite && !(done_next && !done_reg)) begin
      done_next = 1'b0;
    end
    if (acquisitionTypeWrite && !done_reg && step_reg == ST_IDLE) begin
      type_next = acquisitionTypeIn;
    end
    busy_next = (step_next != ST_IDLE);
    pump_next = (step_next == ST_IDLE) || (step_next == ST_INIT)
                || (step_next == ST_SETTLE) || (step_next == ST_RECOVER);
  end

  // duration of the step being entered
  always_comb begin
    unique case (step_next)
      ST_INIT: loadCount = TMR_W'(INIT_CYC);
      ST_SETTLE: loadCount = settleCyc;
      ST_BLK1, ST_BLK2: loadCount = TMR_W'(BLK_PHASE_CYC);
      ST_SETUP: loadCount = TMR_W'(CELL_SETUP_CYC);
      ST_CELL_UP, ST_CELL_DN: loadCount = TMR_W'(CELL_PHASE_CYC);
      ST_DIAG1A, ST_DIAG1B: loadCount = d1Cyc;
      ST_DIAG2A, ST_DIAG2B: loadCount = d2Cyc;
      ST_AUX: loadCount = TMR_W'(AUX_CH_CYC * count_ones(NUM_CELLS'(aux_reg)));
      ST_RECOVER: loadCount = TMR_W'(RECOVER_CYCLES);
      ST_ENDPOINT: loadCount = TMR_W'(ENDPOINT_CYC);
      ST_COMPARATOR_ACCURACY_CHECK: loadCount = TMR_W'(COMPARATOR_ACCURACY_CHECK_CYC);
      default: loadCount = TMR_W'(1);
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_reg <= ST_IDLE;
      cell_reg <= 5'h00;
      cyc_reg <= 8'h00;
      done_reg <= 1'b0;
      type_reg <= TYPE_RESET;
      busy_reg <= 1'b0;
      pump_reg <= 1'b1;
      strobeRb_reg <= 1'b0;
    end else begin
      step_reg <= step_next;
      cell_reg <= cell_next;
      cyc_reg <= cyc_next;
      done_reg <= done_next;
      type_reg <= type_next;
      busy_reg <= busy_next;
      pump_reg <= pump_next;
      strobeRb_reg <= 1'b0;
    end
  end

  // configuration captured at start
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      blk_reg <= 1'b0;
      endp_reg <= 1'b0;
      comp_reg <= 1'b0;
      auto_reg <= 1'b0;
      freeRun_reg <= 1'b0;
      cells_reg <= '0;
      aux_reg <= '0;
      d1_reg <= DIAG_OFF;
      d2_reg <= DIAG_OFF;
      ovsTot_reg <= 8'h01;
      settleT_reg <= 10'h000;
    end else if (latchCfg) begin
      blk_reg <= blockMeasureEnable;
      endp_reg <= adcEndpointCheckEnable;
      comp_reg <= comparatorAccuracyCheckEnable;
      auto_reg <= thermistorBiasAuto;
      freeRun_reg <= (sampleRateSelect == RATE_FREE_RUN);
      cells_reg <= cellEnableMask;
      aux_reg <= auxEnableMask;
      d1_reg <= firstDiagSelect;
      d2_reg <= secondDiagSelect;
      ovsTot_reg <= ovs_total(oversampleCount);
      settleT_reg <= auxSettleTime;
    end
  end

  assign acquireStrobeReadback = strobeRb_reg;
  assign acquisitionDoneFlag = done_reg;
  assign acquisitionTypeField = type_reg;
  assign acquisitionBusy = busy_reg;
  assign hvPumpEnable = pump_reg;
  assign activeStep = step_reg;
  assign activeCell = cell_reg;
  assign oversampleIndex = cyc_reg;
endmodule

// [core/aps_step_timer.sv]
// Purpose: down counter that times one sequencer step
// Assumes: load count of zero is treated as one cycle
// Notes: expire pulses the cycle the count runs out
`timescale 1ns/10ps
module aps_step_timer
  import aps_pkg::*;
#(
  parameter int W = TMR_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // control
  input wire logic load,
  input wire logic [W-1:0] loadCount,
  // status
  output logic expire
);
  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  // from the register only: load is derived from expire upstream
  assign expire = (count_reg == W'(1));

  always_comb begin
    count_next = count_reg;
    if (load) begin
      count_next = (loadCount == '0) ? W'(1) : loadCount;
    end else if (count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule

// [verif/aps_checker.sv]
// Purpose: port-level temporal checks on the pyramid acquisition sequencer
// Assumes: step codes follow aps_step_e order
// Notes: step lengths measured with a run-length counter
`timescale 1ns/10ps
module aps_checker
  import aps_pkg::*;
#(
  parameter int RECOVER_CYCLES = RECOVER_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // host writes and conversion order select
  input wire logic acquireWrite,
  input wire logic acquisitionTypeWrite,
  input wire logic conversionOrderSelect,
  // status
  input wire logic acquireStrobeReadback,
  input wire logic acquisitionDoneFlag,
  input wire logic [3:0] acquisitionTypeField,
  input wire logic acquisitionBusy,
  input wire logic hvPumpEnable,
  input wire logic [4:0] activeStep,
  input wire logic [4:0] activeCell
);
  logic [4:0] lastStep_reg;
  logic [4:0] lastStep_next;
  logic [19:0] runLen_reg;
  logic [19:0] runLen_next;

  always_comb begin
    lastStep_next = activeStep;
    runLen_next = (activeStep != lastStep_reg) ? 20'h1 : runLen_reg + 20'h1;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      lastStep_reg <= 5'h0;
      runLen_reg <= 20'h0;
    end else begin
      lastStep_reg <= lastStep_next;
      runLen_reg <= runLen_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // step just left, runLen holds its length
  sequence sLeave(logic [4:0] s);
    (activeStep != lastStep_reg) && (lastStep_reg == s);
  endsequence
  sequence sStart;
    acquireWrite && !conversionOrderSelect && (activeStep == ST_IDLE);
  endsequence

  a_strobe_zero: assert property (acquireStrobeReadback == 1'b0)
    else $error("acquire strobe read back nonzero");
  a_start_init: assert property (sStart |=> acquisitionBusy && activeStep == ST_INIT)
    else $error("start did not enter init");
  a_order_refused: assert property (acquireWrite && conversionOrderSelect &&
    activeStep == ST_IDLE |=> activeStep == ST_IDLE)
    else $error("start taken with non-pyramid order");
  a_type_locked: assert property (acquisitionTypeWrite && acquisitionDoneFlag
    |=> $stable(acquisitionTypeField))
    else $error("type field changed while done set");
  a_pump_off: assert property (activeStep inside {[ST_PUMP_OFF:ST_AUX]} |-> !hvPumpEnable)
    else $error("pump on during measurement");
  a_recover_pump: assert property (activeStep == ST_RECOVER |-> hvPumpEnable)
    else $error("pump off during recovery");
  a_pump_step: assert property (sLeave(ST_PUMP_OFF) |-> runLen_reg == 20'h1)
    else $error("pump-off step not one cycle");
  a_init_len: assert property (sLeave(ST_INIT) |-> runLen_reg == INIT_CYC)
    else $error("init length wrong");
  a_recover_len: assert property (sLeave(ST_RECOVER) |->
    runLen_reg == RECOVER_CYCLES && activeStep == ST_PUMP_OFF)
    else $error("recovery length or successor wrong");
  a_done_end: assert property ($fell(acquisitionBusy) |->
    acquisitionDoneFlag && activeStep == ST_IDLE)
    else $error("busy fell without done");
  a_cell_up: assert property (activeStep == ST_CELL_UP && $past(activeStep) == ST_CELL_UP
    && $changed(activeCell) |-> activeCell > $past(activeCell))
    else $error("cells not ascending");
  a_cell_down: assert property (activeStep == ST_CELL_DN && $past(activeStep) == ST_CELL_DN
    && $changed(activeCell) |-> activeCell < $past(activeCell))
    else $error("cells not descending");
endmodule

bind aps_sequencer aps_checker #(.RECOVER_CYCLES(RECOVER_CYCLES)) i_aps_checker (
  .clk, .rst_b, .acquireWrite, .acquisitionTypeWrite, .conversionOrderSelect,
  .acquireStrobeReadback, .acquisitionDoneFlag, .acquisitionTypeField, .acquisitionBusy,
  .hvPumpEnable, .activeStep, .activeCell
);

// [verif/aps_host_model.sv]
// Purpose: host controller at the far end of a daisy chain
// Assumes: bench requests are one-cycle pulses set at the falling edge
// Notes: every write reaches the device after the chain delay
`timescale 1ns/10ps
module aps_host_model #(
  parameter int CHAIN_DELAY = 3
) (
  // clock
  input wire logic clk,
  // requests from the bench
  input wire logic cmdStart,
  input wire logic cmdType,
  input wire logic [3:0] cmdTypeVal,
  input wire logic cmdClear,
  // writes as they reach the device
  output logic acquireWrite,
  output logic acquisitionTypeWrite,
  output logic [3:0] acquisitionTypeIn,
  output logic doneClearWrite
);
  logic [6:0] pipe [CHAIN_DELAY];

  initial for (int i = 0; i < CHAIN_DELAY; i++) pipe[i] = 7'h0;

  // idle data lines show the inverse of the last value
  always @(negedge clk) begin
    pipe[0] <= {cmdStart, cmdType, cmdType ? cmdTypeVal : ~pipe[0][4:1], cmdClear};
    for (int i = 1; i < CHAIN_DELAY; i++) pipe[i] <= pipe[i-1];
  end

  assign {acquireWrite, acquisitionTypeWrite, acquisitionTypeIn, doneClearWrite} =
    pipe[CHAIN_DELAY-1];
endmodule

// [verif/aps_sequencer_tb_top.sv]
// Purpose: self-checking bench for the pyramid acquisition sequencer
// Assumes: shortened recovery and alternate-reference counts
// Notes: durations counted in cycles with busy high
`timescale 1ns/10ps
module aps_sequencer_tb_top
  import aps_pkg::*;
();
  localparam int REC = 20;
  localparam int ALT = 10;
  localparam int DLY = 3;
  logic clk, rst_b, cmdStart, cmdType, cmdClear, acquireWrite, acquisitionTypeWrite;
  logic [3:0] cmdTypeVal, acquisitionTypeIn, firstDiagSelect, secondDiagSelect;
  logic doneClearWrite, conversionOrderSelect, blockMeasureEnable, thermistorBiasAuto;
  logic [2:0] oversampleCount;
  logic [13:0] cellEnableMask;
  logic [5:0] auxEnableMask;
  logic [9:0] auxSettleTime;
  logic [1:0] sampleRateSelect;
  logic adcEndpointCheckEnable, comparatorAccuracyCheckEnable, acquireStrobeReadback;
  logic acquisitionDoneFlag, acquisitionBusy, hvPumpEnable;
  logic [3:0] acquisitionTypeField;
  logic [4:0] activeStep, activeCell;
  logic [7:0] oversampleIndex;
  int errors = 0;
  int nTests = 0;
  int pumpLow;

  aps_sequencer #(.RECOVER_CYCLES(REC), .ALTREF_CYCLES(ALT)) i_aps_sequencer (
    .clk, .rst_b, .acquireWrite, .acquisitionTypeWrite, .acquisitionTypeIn, .doneClearWrite,
    .conversionOrderSelect, .oversampleCount, .blockMeasureEnable, .cellEnableMask,
    .firstDiagSelect, .secondDiagSelect, .auxEnableMask, .auxSettleTime, .thermistorBiasAuto,
    .sampleRateSelect, .adcEndpointCheckEnable, .comparatorAccuracyCheckEnable,
    .acquireStrobeReadback, .acquisitionDoneFlag, .acquisitionTypeField, .acquisitionBusy,
    .hvPumpEnable, .activeStep, .activeCell, .oversampleIndex);

  aps_host_model #(.CHAIN_DELAY(DLY)) i_aps_host_model (
    .clk, .cmdStart, .cmdType, .cmdTypeVal, .cmdClear, .acquireWrite,
    .acquisitionTypeWrite, .acquisitionTypeIn, .doneClearWrite);

  task automatic final_report();
    if (errors == 0 && nTests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic hang();
    errors++;
    final_report();
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic cfg(input logic [2:0] o, input logic b, input logic [13:0] c,
      input logic [3:0] d1, input logic [3:0] d2, input logic [5:0] a, input logic [9:0] s,
      input logic t, input logic [1:0] r, input logic e);
    oversampleCount <= o;
    blockMeasureEnable <= b;
    cellEnableMask <= c;
    firstDiagSelect <= d1;
    secondDiagSelect <= d2;
    auxEnableMask <= a;
    auxSettleTime <= s;
    thermistorBiasAuto <= t;
    sampleRateSelect <= r;
    adcEndpointCheckEnable <= e;
    comparatorAccuracyCheckEnable <= e;
  endtask

  task automatic pulse(input int which, input logic [3:0] v);
    cmdStart <= (which == 0);
    cmdType <= (which == 1);
    cmdTypeVal <= v;
    cmdClear <= (which == 2);
    @(negedge clk);
    cmdStart <= 1'b0;
    cmdType <= 1'b0;
    cmdClear <= 1'b0;
  endtask

  // start, time the chain latency and the busy span, one stray start mid-run at bumpAt unless it is negative
  task automatic run_acq(input int expDur, input int bumpAt);
    int lat;
    int dur;
    lat = 1;
    dur = 0;
    pumpLow = 0;
    pulse(0, 4'h0);
    while (acquisitionBusy !== 1'b1) begin
      if (lat > 50) hang();
      @(negedge clk);
      lat++;
    end
    while (acquisitionBusy === 1'b1) begin
      if (dur > 100000) hang();
      cmdStart <= (dur == bumpAt);
      pumpLow += (hvPumpEnable === 1'b0);
      @(negedge clk);
      dur++;
    end
    chk("start latency", lat, DLY + 1);
    chk("busy span", dur, expDur);
    chk("done flag", acquisitionDoneFlag, 1'b1);
  endtask

  task automatic t_reset();
    chk("strobe", acquireStrobeReadback, 1'b0);
    chk("idle state", {acquisitionDoneFlag, acquisitionBusy, hvPumpEnable, activeStep}, 8'h20);
    chk("type and index", {acquisitionTypeField, oversampleIndex}, 12'h0);
  endtask

  task automatic t_minimal();
    cfg(3'h0, 1'b0, 14'h0, 4'h0, 4'h0, 6'h0, 10'h0, 1'b0, 2'h0, 1'b0);
    run_acq(1876, 3);
    chk("pump low", pumpLow, 1);
    chk("strobe", acquireStrobeReadback, 1'b0);
    pulse(1, 4'h3);
    cycles(DLY + 2);
    chk("type locked", acquisitionTypeField, 4'h0);
    pulse(2, 4'h0);
    cycles(DLY + 2);
    chk("done cleared", acquisitionDoneFlag, 1'b0);
    pulse(1, 4'h3);
    cycles(DLY + 2);
    chk("type written", acquisitionTypeField, 4'h3);
    conversionOrderSelect <= 1'b1;
    pulse(0, 4'h0);
    cycles(DLY + 5);
    chk("order refused", {acquisitionBusy, activeStep}, 6'h0);
    conversionOrderSelect <= 1'b0;
  endtask

  task automatic t_diag_codes();
    int ph [7] = '{2028, 1489, 528, 1518, ALT, 1219, 340};
    for (int c = 1; c <= 7; c++) begin
      cfg(3'h0, 1'b0, 14'h0, 4'(c), 4'h0, 6'h0, 10'h0, 1'b0, 2'h0, 1'b0);
      run_acq(1876 + 2 * ph[c-1], -1);
    end
  endtask

  task automatic t_full();
    int cyc;
    cyc = 1 + 2 * 1735 + 798 + 4 * 563 + 4 * 340 + 2 * 680;
    cfg(3'h1, 1'b1, 14'h0005, 4'h7, 4'h7, 6'h03, 10'h0, 1'b0, 2'h0, 1'b1);
    run_acq(1875 + 4 * cyc + 3 * REC + 1400 + 1688, 100);
    chk("pump low", pumpLow, 4 * cyc + 1400 + 1688);
    chk("oversample index", oversampleIndex, 8'h03);
  endtask

  task automatic t_settle();
    cfg(3'h0, 1'b0, 14'h0, 4'h5, 4'h0, 6'h01, 10'h002, 1'b1, 2'h1, 1'b0);
    run_acq(1875 + 1500 + 1 + 2 * ALT + 680, -1);
    cfg(3'h0, 1'b0, 14'h0, 4'h5, 4'h0, 6'h01, 10'h00a, 1'b1, 2'h0, 1'b0);
    run_acq(1875 + (7500 - 1875 - 2 * ALT) + 1 + 2 * ALT + 680, -1);
  endtask

  task automatic t_mid_reset();
    pulse(0, 4'h0);
    cycles(100);
    rst_b <= 1'b0;
    cycles(2);
    chk("reset mid-run", {acquisitionDoneFlag, acquisitionBusy, hvPumpEnable, activeStep}, 8'h20);
    rst_b <= 1'b1;
    cycles(2);
    cfg(3'h0, 1'b0, 14'h0, 4'h0, 4'h0, 6'h0, 10'h0, 1'b0, 2'h0, 1'b0);
    run_acq(1876, -1);
  endtask

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    rst_b = 1'b0;
    cmdStart = 1'b0;
    cmdType = 1'b0;
    cmdTypeVal = 4'h0;
    cmdClear = 1'b0;
    conversionOrderSelect = 1'b0;
    cfg(3'h0, 1'b0, 14'h0, 4'h0, 4'h0, 6'h0, 10'h0, 1'b0, 2'h0, 1'b0);
    cycles(20);
    rst_b <= 1'b1;
    @(negedge clk);
    t_reset();
    t_minimal();
    t_diag_codes();
    t_full();
    t_settle();
    t_mid_reset();
    final_report();
  end
endmodule
